// File: src/sfspi_cfg.svh
`ifndef SFSPI_CFG_SVH
`define SFSPI_CFG_SVH
`define SFSPI_WORD_BITS     4'h8
`define SFSPI_PROT_PAGES    12'h100
`define SFSPI_PAGE_BITS     11
`define SFSPI_CLK_NS        4
`define SFSPI_BUSY_US       2
`define SFSPI_BUSY_CYC      ((`SFSPI_BUSY_US * 1000) / `SFSPI_CLK_NS)
`define SFSPI_CMD_PROGRAM   8'h82
`define SFSPI_CMD_READ      8'h52
`define SFSPI_SHIFT_RST     8'h00
`endif

// File: src/sfspi_pkg.sv
package sfspi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA} sfspi_phase_type;
endpackage

// File: src/sfspi_busy_timer.sv
`timescale 1ns/1ps
`include "sfspi_cfg.svh"
// self-timed operation counter, runs on the system clock only
module sfspi_busy_timer
  import sfspi_pkg::*;
#(
  parameter int unsigned BUSY_CYC = `SFSPI_BUSY_CYC
)
(
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic start_in,
  output logic      busy_out
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cnt_ff <= 32'h0;
    end
    else if (start_in && cnt_ff == 32'h0)
    begin
      cnt_ff <= BUSY_CYC;
    end
    else if (cnt_ff != 32'h0)
    begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end
  assign busy_out = (cnt_ff != 32'h0);
endmodule

// File: src/sfspi_front_end.sv
`timescale 1ns/1ps
`include "sfspi_cfg.svh"
module sfspi_front_end
  import sfspi_pkg::*;
#(
  parameter int unsigned BUSY_CYC = `SFSPI_BUSY_CYC
)
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        SRST_IN,
  input  wire logic        SCK_IN,
  input  wire logic        SERIAL_IN,
  input  wire logic        CHIP_SELECT_N_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        WRITE_PROTECT_N_IN,
  input  wire logic [7:0]  READ_DATA_IN,
  output logic             SERIAL_OUT,
  output logic             SERIAL_OE_OUT,
  output logic             READY_BUSY_N_OUT,
  output logic [7:0]       WORD_OUT,
  output logic             WORD_VALID_OUT,
  output logic             PROGRAM_START_OUT,
  output logic             READ_START_OUT,
  output logic             PROTECT_REFUSED_OUT,
  output logic [10:0]      PAGE_OUT
);
  ////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; first stage feeds only the second
  logic [1:0] sck_s_ff, si_s_ff, cs_s_ff, rst_s_ff, wp_s_ff;
  logic       sck_d_ff, cs_d_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      sck_s_ff <= 2'h0;
      si_s_ff  <= 2'h0;
      cs_s_ff  <= 2'h3;
      rst_s_ff <= 2'h3;
      wp_s_ff  <= 2'h3;
      sck_d_ff <= 1'h0;
      cs_d_ff  <= 1'h1;
    end
    else
    begin
      sck_s_ff <= {sck_s_ff[0], SCK_IN};
      si_s_ff  <= {si_s_ff[0], SERIAL_IN};
      cs_s_ff  <= {cs_s_ff[0], CHIP_SELECT_N_IN};
      rst_s_ff <= {rst_s_ff[0], RESET_N_IN};
      wp_s_ff  <= {wp_s_ff[0], WRITE_PROTECT_N_IN};
      sck_d_ff <= sck_s_ff[1];
      cs_d_ff  <= cs_s_ff[1];
    end
  end
  logic cs_n, sck_rise, sck_fall, cs_rise, dev_rst;
  assign cs_n     = cs_s_ff[1];
  assign dev_rst  = SRST_IN | ~rst_s_ff[1];
  // serial clock is only observed, mode 0 and 3 differ only in idle level
  assign sck_rise = ~sck_d_ff & sck_s_ff[1] & ~cs_n;
  assign sck_fall = sck_d_ff & ~sck_s_ff[1] & ~cs_n;
  assign cs_rise  = ~cs_d_ff & cs_n;
  ////////////////////////////////////////////////////////////////////////////////
  // receive shifter
  logic [7:0] sh_ff;
  logic [2:0] bit_ff;
  logic       word_done;
  assign word_done = sck_rise && bit_ff == 3'h7;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst || cs_n)
    begin
      sh_ff  <= `SFSPI_SHIFT_RST;
      bit_ff <= 3'h0;
    end
    else if (sck_rise)
    begin
      sh_ff  <= {sh_ff[6:0], si_s_ff[1]};
      bit_ff <= bit_ff + 3'h1;
    end
  end
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst)
    begin
      WORD_OUT       <= 8'h00;
      WORD_VALID_OUT <= 1'h0;
    end
    else
    begin
      WORD_VALID_OUT <= word_done;
      if (word_done)
      begin
        WORD_OUT <= {sh_ff[6:0], si_s_ff[1]};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // command phase tracking
  sfspi_phase_type phase_ff;
  logic [7:0]  cmd_ff;
  logic [1:0]  addr_cnt_ff;
  logic [10:0] page_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst || cs_n)
    begin
      phase_ff    <= ST_IDLE;
      addr_cnt_ff <= 2'h0;
    end
    else
    begin
      case (phase_ff)
        ST_IDLE: phase_ff <= ST_CMD;
        ST_CMD:
        begin
          if (word_done)
          begin
            phase_ff <= ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          if (word_done)
          begin
            addr_cnt_ff <= addr_cnt_ff + 2'h1;
            if (addr_cnt_ff == 2'h2)
            begin
              phase_ff <= ST_DATA;
            end
          end
        end
        ST_DATA: phase_ff <= ST_DATA;
        default: phase_ff <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst)
    begin
      cmd_ff  <= 8'h00;
      page_ff <= 11'h000;
    end
    else if (word_done && phase_ff == ST_CMD)
    begin
      cmd_ff <= {sh_ff[6:0], si_s_ff[1]};
    end
    else if (word_done && phase_ff == ST_ADDR && addr_cnt_ff == 2'h0)
    begin
      page_ff[10:7] <= {sh_ff[2:0], si_s_ff[1]};
    end
    else if (word_done && phase_ff == ST_ADDR && addr_cnt_ff == 2'h1)
    begin
      page_ff[6:0] <= sh_ff[6:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // deselect triggers the self-timed operation
  logic busy, is_prog, is_read, refuse, start_op;
  logic had_cmd_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst || cs_rise)
    begin
      had_cmd_ff <= 1'h0;
    end
    else if (word_done && phase_ff == ST_ADDR && addr_cnt_ff == 2'h2)
    begin
      had_cmd_ff <= 1'h1;
    end
  end
  assign is_prog  = cmd_ff == `SFSPI_CMD_PROGRAM;
  assign is_read  = cmd_ff == `SFSPI_CMD_READ;
  // page numbers below the protected count are locked while protect is low
  assign refuse   = is_prog && ~wp_s_ff[1] && ({1'b0, page_ff} < `SFSPI_PROT_PAGES);
  assign start_op = cs_rise && had_cmd_ff && ~busy && (is_read || (is_prog && ~refuse));
  sfspi_busy_timer #(.BUSY_CYC(BUSY_CYC)) u_timer
  (
    .clk_in   (CLK_SYS_IN),
    .srst_in  (dev_rst),
    .start_in (start_op),
    .busy_out (busy)
  );
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst)
    begin
      PROGRAM_START_OUT   <= 1'h0;
      READ_START_OUT      <= 1'h0;
      PROTECT_REFUSED_OUT <= 1'h0;
      READY_BUSY_N_OUT    <= 1'h1;
      PAGE_OUT            <= 11'h000;
    end
    else
    begin
      PROGRAM_START_OUT   <= start_op && is_prog;
      READ_START_OUT      <= start_op && is_read;
      PROTECT_REFUSED_OUT <= cs_rise && had_cmd_ff && refuse;
      READY_BUSY_N_OUT    <= ~(busy | start_op);
      PAGE_OUT            <= page_ff;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // transmit: load a byte once a word is in, shift on the next falling edges
  logic [7:0] tx_ff;
  logic       tx_arm_ff;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (dev_rst || cs_n)
    begin
      tx_ff         <= 8'h00;
      tx_arm_ff     <= 1'h0;
      SERIAL_OUT    <= 1'h0;
      SERIAL_OE_OUT <= 1'h0;
    end
    else
    begin
      if (word_done)
      begin
        tx_ff     <= READ_DATA_IN;
        tx_arm_ff <= 1'h1;
      end
      else if (sck_fall && tx_arm_ff)
      begin
        // the fall after the sampling rise drives the bit, never the same cycle
        SERIAL_OUT    <= tx_ff[7];
        SERIAL_OE_OUT <= 1'h1;
        tx_ff         <= {tx_ff[6:0], 1'b0};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  p_hiz_deselect: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    $past(cs_n) && cs_n |-> !SERIAL_OE_OUT)
    else $error("serial out driven while deselected");
  p_busy_on_start: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    start_op |=> !READY_BUSY_N_OUT [*3])
    else $error("ready not low after start");
  p_prog_refused: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    refuse |-> !start_op)
    else $error("protected page programmed");
  p_start_on_cs: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    PROGRAM_START_OUT |-> $past(cs_rise))
    else $error("program start without deselect");
  p_word_eight: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    WORD_VALID_OUT |-> $past(bit_ff) == 3'h7)
    else $error("word not eight bits");
  p_out_on_fall: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    !cs_n && $changed(SERIAL_OUT) |-> $past(sck_fall))
    else $error("output moved off falling edge");
  p_idle_on_cs: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    cs_n |=> phase_ff == ST_IDLE && bit_ff == 3'h0)
    else $error("not idle when deselected");
  p_no_start_busy: assert property (@(posedge CLK_SYS_IN) disable iff (dev_rst)
    busy |-> !start_op)
    else $error("start while busy");
  c_word: cover property (@(posedge CLK_SYS_IN) WORD_VALID_OUT);
  c_prog: cover property (@(posedge CLK_SYS_IN) PROGRAM_START_OUT);
  c_read: cover property (@(posedge CLK_SYS_IN) READ_START_OUT);
  c_refuse: cover property (@(posedge CLK_SYS_IN) PROTECT_REFUSED_OUT);
endmodule

// File: dv/sfspi_master_model.sv
`timescale 1ns/1ps
module sfspi_master_model
(
  input  wire logic so_in,
  input  wire logic oe_in,
  output logic      sck_out,
  output logic      si_out,
  output logic      cs_n_out
);
  initial
  begin
    sck_out  = 1'b0;
    si_out   = 1'b0;
    cs_n_out = 1'b1;
  end
  ////////////////////////////////////////
  // mode 0 master, 32 ns bit time; clock stands low between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n_out = 1'b0;
    #16;
    for (int i = 31; i >= 0; i--)
    begin
      si_out = tx[i];
      #16 sck_out = 1'b1;
      // late sample: the oversampled output lags the pin fall by a few sys cycles
      #15 rx[i] = oe_in ? so_in : ~so_in;
      #1 sck_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    si_out = ~si_out;
  endtask
endmodule

// File: dv/test_serial_flash_spi_front_end.sv
`timescale 1ns/1ps
module test_serial_flash_spi_front_end;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        rstn = 1'b1;
  logic        wpn = 1'b1;
  logic [7:0]  rdat = 8'h00;
  logic        sck, si, csn, so, oe, rb, wv, ps, rs, pref;
  logic [7:0]  word;
  logic [10:0] page;
  logic [15:0] seed = 16'hD547;
  logic [23:0] a;
  int          n_fail = 0;
  int          n_tests = 0;
  int          desel = 0;
  int          wvn = 0;
  always #2 clk = ~clk;
  sfspi_front_end #(.BUSY_CYC(20)) uut (.CLK_SYS_IN(clk), .SRST_IN(srst), .SCK_IN(sck), .SERIAL_IN(si),
    .CHIP_SELECT_N_IN(csn), .RESET_N_IN(rstn), .WRITE_PROTECT_N_IN(wpn), .READ_DATA_IN(rdat),
    .SERIAL_OUT(so), .SERIAL_OE_OUT(oe), .READY_BUSY_N_OUT(rb), .WORD_OUT(word), .WORD_VALID_OUT(wv),
    .PROGRAM_START_OUT(ps), .READ_START_OUT(rs), .PROTECT_REFUSED_OUT(pref), .PAGE_OUT(page));
  sfspi_master_model m (.so_in(so), .oe_in(oe), .sck_out(sck), .si_out(si), .cs_n_out(csn));
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    wvn <= wvn + wv;
    desel <= csn ? desel + 1 : 0;
    if (desel > 8)
      chk("oe while deselected", oe, 1'b0);
  end
  task frame(input logic [7:0] cmd, input logic [23:0] addr, input logic wp);
    logic [31:0] rx;
    logic [7:0]  d;
    logic        refuse;
    int          busy, np, nr, nf;
    busy = 0;
    np = 0;
    nr = 0;
    nf = 0;
    seed = lfsr(seed);
    d = seed[7:0];
    refuse = cmd == 8'h82 && !wp && addr[19:9] < 12'h100;
    @(posedge clk);
    wpn <= wp;
    rdat <= d;
    @(negedge clk);
    wvn = 0;
    m.xfer({cmd, addr}, rx);
    // long enough for the start pulse and the whole busy span
    repeat (60)
    begin
      @(negedge clk);
      np += ps;
      nr += rs;
      nf += pref;
      busy += !rb;
    end
    chk("serial out bytes", rx[23:0], {d, d, d});
    chk("word count", wvn, 4);
    chk("last word", word, addr[7:0]);
    chk("page", page, addr[19:9]);
    chk("program start", np, cmd == 8'h82 && !refuse);
    chk("read start", nr, cmd == 8'h52);
    chk("refused", nf, refuse);
    chk("busy cycles", busy, refuse ? 0 : 21);
    $display("frame cmd %h addr %h done", cmd, addr);
  endtask
  ////////////////////////////////////////
  initial
  begin
    #60000;
    n_fail++;
    $display("watchdog expired");
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("ready after reset", rb, 1'b1);
    frame(8'h82, 24'h01FE00, 1'b0);
    frame(8'h82, 24'h020000, 1'b0);
    frame(8'h52, 24'h000000, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      a[23:8] = seed;
      seed = lfsr(seed);
      a[7:0] = seed[7:0];
      frame(seed[9] ? 8'h82 : 8'h52, a, seed[10]);
    end
    // mid-run device reset through the pin, then one more frame
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(negedge clk);
    chk("word in device reset", word, 8'h00);
    chk("ready in device reset", rb, 1'b1);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    frame(8'h52, 24'h000100, 1'b1);
    end_sim;
  end
endmodule
